// ---- vsc_pkg.sv ----
// package of constants and carrier types for the syscon and strap configuration block
package vsc_pkg;

  // register byte offsets on the wishbone bus
  localparam logic [7:0] VSC_OFS_STATUS  = 8'h00;  // status_reg_one, read only
  localparam logic [7:0] VSC_OFS_MODE    = 8'h04;  // mode register
  localparam logic [7:0] VSC_OFS_GENERAL_CONTROL_REG  = 8'h08;  // general_control_reg
  localparam logic [7:0] VSC_OFS_L7IE    = 8'h0c;  // level_seven_enable_reg
  localparam logic [7:0] VSC_OFS_VIE     = 8'h10;  // vme_irq_enable_reg
  localparam logic [7:0] VSC_OFS_BASE    = 8'h14;  // slave_base_addr_reg
  localparam logic [7:0] VSC_OFS_ISOCTL  = 8'h18;  // isolation control

  // status field positions
  localparam int VSC_ST_SYSCON   = 0;
  localparam int VSC_ST_CFG1     = 1;
  localparam int VSC_ST_CFG2     = 2;
  localparam int VSC_ST_ISO      = 3;
  localparam int VSC_ST_AUTOBASE = 4;
  localparam int VSC_ST_OFFRST   = 5;

  // control field positions
  localparam int VSC_MODE_RMWSEL = 0;  // 1 selects retry, 0 rmw cycle pin
  localparam int VSC_GEN_I1ISO   = 0;  // irq1_isolation_select
  localparam int VSC_L7_ISOEN    = 0;  // isolation_irq_enable
  localparam int VSC_VIE_L1      = 1;  // level 1 enable bit
  localparam int VSC_ISO_SOFT    = 0;  // soft_isolation_bit
  localparam int VSC_ISO_A24EN   = 1;  // a24 slave image enable
  localparam int VSC_ISO_A32EN   = 2;  // a32 slave image enable

  // reset values
  localparam logic       VSC_RST_RMWSEL = 1'b0;  // rmw cycle function after reset
  localparam logic       VSC_RST_I1ISO  = 1'b1;  // irq1 starts as isolation initiator
  localparam logic [7:0] VSC_RST_L7IE   = 8'h00;
  localparam logic [7:0] VSC_RST_VIE    = 8'h00;
  localparam logic [31:0] VSC_RST_BASE  = 32'h0000_0000;
  localparam logic [7:0] VSC_RST_ISOCTL = 8'h01;  // reset itself enters isolation

  // wishbone request carrier
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } vsc_wb_req_t;

  // local bus register request carrier
  typedef struct packed {
    logic        strobe;
    logic        we;
    logic [7:0]  adr;
    logic [31:0] dat;
  } vsc_lb_req_t;

endpackage

// ---- vsc_syscon.sv ----
// syscon detect, grant reuse, dual pin, bus isolation and auto base strap logic
// Behaviour
// - sample syscon grant at reset, low means syscon
// - syscon uses offcard grant as reset input
// - syscon exposes config grants in status only
// - mode bit picks retry or rmw pin
// - rmw pin bidirectional, strobe direction steers buffer
// - retry mode never drives dual pin
// - isolation from reset, pin, soft bit, irq1
// - irq1 is isolation initiator after reset
// - irq1 isolation raises enabled level seven interrupt
// - irq1 plain source raises enabled level one
// - clearing select bit makes irq1 interrupt only
// - auto base when fc2 high, fc0 low
// - auto base loads base register, enables slave
// - vme register access forwarded as local cycle
// - selected register access ended by size acknowledge
// - register access through a24 or a32 images
`timescale 1ns/100ps
module vsc_syscon
  import vsc_pkg::*;
(
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  // power-on reset and strap pins
  input  wire logic        i_power_on_reset_in_b,
  input  wire logic        i_local_function_code_2,
  input  wire logic        i_local_function_code_0,
  input  wire logic [31:0] i_local_data,
  // bus grant inputs, active low
  input  wire logic        i_syscon_detect_grant_in_b,
  input  wire logic        i_offcard_reset_grant_in_b,
  input  wire logic        i_config_grant_in_first_b,
  input  wire logic        i_config_grant_in_second_b,
  // isolation and irq1 inputs, active low
  input  wire logic        i_isolation_trigger_pin_b,
  input  wire logic        i_irq1_b,
  // dual purpose pin and strobe direction from vme master logic
  input  wire logic        i_rmw_cycle_pin_in_b,
  input  wire logic        i_rmw_drive_req,
  input  wire logic        i_strobe_out_req,
  // forwarded vme slave access
  input  wire logic        i_vme_slave_req,
  input  wire logic        i_vme_slave_a32,
  input  wire logic        i_vme_slave_we,
  input  wire logic [7:0]  i_vme_slave_adr,
  input  wire logic [31:0] i_vme_slave_dat,
  // local bus register access
  input  wire logic        i_device_chip_select,
  input  wire logic        i_local_strobe,
  input  wire logic        i_local_we,
  input  wire logic [7:0]  i_local_adr,
  input  wire logic [31:0] i_local_wdat,
  // wishbone slave
  input  wire vsc_wb_req_t i_wb,
  output logic             o_wb_ack,
  output logic [31:0]      o_wb_dat,
  // status outputs
  output logic             o_syscon,
  output logic             o_offcard_sys_reset,
  output logic             o_bus_isolation_mode,
  output logic             o_retry_in,
  output logic             o_rmw_cycle_pin_out_b,
  output logic             o_rmw_cycle_pin_oe,
  output logic             o_strobe_buffer_direction,
  output logic             o_level7_irq,
  output logic             o_level1_irq,
  output vsc_lb_req_t      o_local_cycle,
  output logic             o_local_size_ack,
  output logic [31:0]      o_local_rdat
);

  // register state
  logic        syscon_q;        // latched syscon decision
  logic        sampled_q;       // sample taken since reset
  logic        rmwsel_q;        // 1 retry, 0 rmw pin
  logic        i1iso_q;         // irq1 isolation select
  logic [7:0]  l7ie_q;          // level seven enables
  logic [7:0]  vie_q;           // vme irq enables
  logic [31:0] base_q;          // slave base address
  logic [7:0]  isoctl_q;        // soft isolation and image enables
  logic        autobase_q;      // auto base option taken
  logic        pwr_q;           // delayed power-on reset level
  logic        ack_q;           // wishbone ack
  logic        lack_q;          // local size ack
  logic [31:0] rdat_q;          // wishbone read data
  logic [31:0] lrdat_q;         // local read data
  vsc_lb_req_t lcyc_q;          // forwarded local cycle
  logic        wb_wr;           // wishbone write strobe
  logic        lb_wr;           // local write strobe
  logic        pwr_rise;        // power-on reset release edge
  logic        auto_strap;      // strap combination present

  // register read mux, shared by both ports
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    rd_mux = 32'h0000_0000;
    case (a)
      VSC_OFS_STATUS: begin
        rd_mux[VSC_ST_SYSCON]   = syscon_q;
        // config grants visible only to software when syscon
        rd_mux[VSC_ST_CFG1]     = syscon_q & ~i_config_grant_in_first_b;
        rd_mux[VSC_ST_CFG2]     = syscon_q & ~i_config_grant_in_second_b;
        rd_mux[VSC_ST_ISO]      = o_bus_isolation_mode;
        rd_mux[VSC_ST_AUTOBASE] = autobase_q;
        rd_mux[VSC_ST_OFFRST]   = o_offcard_sys_reset;
      end
      VSC_OFS_MODE:   rd_mux[VSC_MODE_RMWSEL] = rmwsel_q;
      VSC_OFS_GENERAL_CONTROL_REG: rd_mux[VSC_GEN_I1ISO]   = i1iso_q;
      VSC_OFS_L7IE:   rd_mux[7:0] = l7ie_q;
      VSC_OFS_VIE:    rd_mux[7:0] = vie_q;
      VSC_OFS_BASE:   rd_mux = base_q;
      VSC_OFS_ISOCTL: rd_mux[7:0] = isoctl_q;
      default:        rd_mux = 32'h0000_0000;
    endcase
  endfunction

  // write strobes; a local write wins over wishbone in the same cycle
  assign wb_wr      = i_wb.cyc & i_wb.stb & i_wb.we & ~ack_q & i_wb.sel[0];
  assign lb_wr      = i_device_chip_select & i_local_strobe & i_local_we & ~lack_q;
  assign pwr_rise   = i_power_on_reset_in_b & ~pwr_q;
  assign auto_strap = i_local_function_code_2 & ~i_local_function_code_0;

  // syscon sample on first clock after reset release
  // sample detect grant
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      syscon_q  <= 1'b0;
      sampled_q <= 1'b0;
    end else if (!sampled_q) begin
      syscon_q  <= ~i_syscon_detect_grant_in_b;
      sampled_q <= 1'b1;
    end
  end

  assign o_offcard_sys_reset = syscon_q & ~i_offcard_reset_grant_in_b;
  assign o_syscon = syscon_q;

  // power-on reset edge tracker
  // resets to the idle high level so a system reset alone never fakes a strap edge
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pwr_q <= 1'b1;
    end else begin
      pwr_q <= i_power_on_reset_in_b;
    end
  end

  // control registers written from wishbone or local bus
  // mode bit select
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rmwsel_q <= VSC_RST_RMWSEL;
      i1iso_q  <= VSC_RST_I1ISO;
      l7ie_q   <= VSC_RST_L7IE;
      vie_q    <= VSC_RST_VIE;
      isoctl_q <= VSC_RST_ISOCTL;
    end else if (pwr_rise && auto_strap) begin
      isoctl_q[VSC_ISO_A24EN] <= 1'b1;
      isoctl_q[VSC_ISO_A32EN] <= 1'b1;
    end else if (lb_wr || wb_wr) begin
      case (lb_wr ? i_local_adr : i_wb.adr)
        VSC_OFS_MODE:   rmwsel_q <= lb_wr ? i_local_wdat[VSC_MODE_RMWSEL]
                                          : i_wb.dat[VSC_MODE_RMWSEL];
        VSC_OFS_GENERAL_CONTROL_REG: i1iso_q  <= lb_wr ? i_local_wdat[VSC_GEN_I1ISO]
                                          : i_wb.dat[VSC_GEN_I1ISO];
        VSC_OFS_L7IE:   l7ie_q   <= lb_wr ? i_local_wdat[7:0] : i_wb.dat[7:0];
        VSC_OFS_VIE:    vie_q    <= lb_wr ? i_local_wdat[7:0] : i_wb.dat[7:0];
        VSC_OFS_ISOCTL: isoctl_q <= lb_wr ? i_local_wdat[7:0] : i_wb.dat[7:0];
        default: ;  // read-only status, base (loaded in its own block) or unmapped offset
      endcase
    end
  end

  // base register, strap load at power-on release
  // strap decode at edge
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      base_q     <= VSC_RST_BASE;
      autobase_q <= 1'b0;
    end else if (pwr_rise && auto_strap) begin
      base_q     <= i_local_data;
      autobase_q <= 1'b1;
    end else if (lb_wr && i_local_adr == VSC_OFS_BASE) begin
      base_q <= i_local_wdat;
    end else if (wb_wr && i_wb.adr == VSC_OFS_BASE) begin
      base_q <= i_wb.dat;
    end
  end

  // dual purpose pin handling
  // rmw pin bidirectional
  assign o_rmw_cycle_pin_out_b     = 1'b0;
  assign o_rmw_cycle_pin_oe        = ~rmwsel_q & i_rmw_drive_req;
  assign o_strobe_buffer_direction = i_strobe_out_req | o_rmw_cycle_pin_oe;
  assign o_retry_in                = rmwsel_q & ~i_rmw_cycle_pin_in_b;

  assign o_bus_isolation_mode = isoctl_q[VSC_ISO_SOFT] | ~i_isolation_trigger_pin_b
                              | (i1iso_q & ~i_irq1_b);

  assign o_level7_irq = i1iso_q & ~i_irq1_b & l7ie_q[VSC_L7_ISOEN];
  assign o_level1_irq = ~i1iso_q & ~i_irq1_b & vie_q[VSC_VIE_L1];

  // forward vme register access as local cycle
  // a24 or a32 image
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lcyc_q <= '0;
    end else begin
      lcyc_q.strobe <= i_vme_slave_req & (i_vme_slave_a32 ? isoctl_q[VSC_ISO_A32EN]
                                                          : isoctl_q[VSC_ISO_A24EN]);
      lcyc_q.we     <= i_vme_slave_we;
      lcyc_q.adr    <= i_vme_slave_adr;
      lcyc_q.dat    <= i_vme_slave_dat;
    end
  end
  assign o_local_cycle = lcyc_q;

  // local slave answer, relies on outside chip select decode
  // chip select from decode
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lack_q  <= 1'b0;
      lrdat_q <= 32'h0000_0000;
    end else begin
      lack_q  <= i_device_chip_select & i_local_strobe & ~lack_q;
      lrdat_q <= rd_mux(i_local_adr);
    end
  end
  assign o_local_size_ack = lack_q;
  assign o_local_rdat     = lrdat_q;

  // wishbone slave: one wait cycle, ack then drop
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= i_wb.cyc & i_wb.stb & ~ack_q;
      rdat_q <= rd_mux(i_wb.adr);
    end
  end
  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;

endmodule

// ---- vsc_syscon_properties.sv ----
// assertion checker on the syscon and strap block ports
`timescale 1ns/100ps
module vsc_chk (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // watched inputs
  input wire logic i_syscon_detect_grant_in_b,
  input wire logic i_offcard_reset_grant_in_b,
  input wire logic i_isolation_trigger_pin_b,
  input wire logic i_irq1_b,
  input wire logic i_device_chip_select,
  input wire logic i_local_strobe,
  // watched outputs
  input wire logic o_syscon,
  input wire logic o_offcard_sys_reset,
  input wire logic o_bus_isolation_mode,
  input wire logic o_retry_in,
  input wire logic o_rmw_cycle_pin_oe,
  input wire logic o_strobe_buffer_direction,
  input wire logic o_level7_irq,
  input wire logic o_level1_irq,
  input wire logic o_local_size_ack
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  logic [1:0] age_q;  // edges since release, saturates
  // age finds the sampling edge after each reset
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) age_q <= 2'h0;
    else if (age_q != 2'h3) age_q <= age_q + 2'h1;
  end
  property p_pick; age_q == 2'h1 |-> o_syscon == !$past(i_syscon_detect_grant_in_b); endproperty
  a_pick: assert property (p_pick) else $error("syscon decision wrong");
  property p_hold; age_q[1] |-> $stable(o_syscon); endproperty
  a_hold: assert property (p_hold) else $error("syscon changed");
  property p_offrst; o_offcard_sys_reset == (o_syscon && !i_offcard_reset_grant_in_b); endproperty
  a_offrst: assert property (p_offrst) else $error("offcard reset wrong");
  property p_dir; o_rmw_cycle_pin_oe |-> o_strobe_buffer_direction; endproperty
  a_dir: assert property (p_dir) else $error("strobe direction wrong");
  property p_retry; o_retry_in |-> !o_rmw_cycle_pin_oe; endproperty
  a_retry: assert property (p_retry) else $error("retry pin driven");
  property p_trig; !i_isolation_trigger_pin_b |-> o_bus_isolation_mode; endproperty
  a_trig: assert property (p_trig) else $error("trigger ignored");
  property p_l1; o_level1_irq |-> !i_irq1_b && !o_level7_irq; endproperty
  a_l1: assert property (p_l1) else $error("level one wrong");
  property p_l7; o_level7_irq |-> !i_irq1_b && o_bus_isolation_mode; endproperty
  a_l7: assert property (p_l7) else $error("level seven wrong");
  property p_ack;
    o_local_size_ack |-> $past(i_device_chip_select) && $past(i_local_strobe) ##1 !o_local_size_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("size ack wrong");
  c_l7: cover property (o_level7_irq);
  c_l1: cover property (o_level1_irq);
  c_ack: cover property (o_local_size_ack);
endmodule
bind vsc_syscon vsc_chk u_chk (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
  .i_syscon_detect_grant_in_b(i_syscon_detect_grant_in_b),
  .i_offcard_reset_grant_in_b(i_offcard_reset_grant_in_b),
  .i_isolation_trigger_pin_b(i_isolation_trigger_pin_b), .i_irq1_b(i_irq1_b),
  .i_device_chip_select(i_device_chip_select), .i_local_strobe(i_local_strobe),
  .o_syscon(o_syscon), .o_offcard_sys_reset(o_offcard_sys_reset),
  .o_bus_isolation_mode(o_bus_isolation_mode), .o_retry_in(o_retry_in),
  .o_rmw_cycle_pin_oe(o_rmw_cycle_pin_oe), .o_strobe_buffer_direction(o_strobe_buffer_direction),
  .o_level7_irq(o_level7_irq), .o_level1_irq(o_level1_irq), .o_local_size_ack(o_local_size_ack));

// ---- vsc_lb_decode.sv ----
// local decode model that selects the block for forwarded cycles
`timescale 1ns/100ps
module vsc_lb_decode
  import vsc_pkg::*;
(
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  // forwarded cycle, its end, and a stall request
  input  wire vsc_lb_req_t i_cycle,
  input  wire logic        i_ack,
  input  wire logic        i_slow,
  // select and local request
  output logic             o_sel,
  output vsc_lb_req_t      o_req
);
  logic done_q;  // one select per forwarded cycle
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sel  <= 1'h0;
      done_q <= 1'h0;
      o_req  <= '0;
    end else if (i_ack) begin
      o_sel  <= 1'h0;
      done_q <= 1'h1;
      o_req  <= ~o_req;  // released lines are inverted on purpose
    end else if (!i_cycle.strobe) begin
      done_q <= 1'h0;
    end else if (!o_sel && !done_q && !i_slow) begin
      o_sel <= 1'h1;
      o_req <= i_cycle;
    end
  end
endmodule

// ---- testbench.sv ----
// self-checking bench for the syscon and strap block
`timescale 1ns/100ps
module testbench
  import vsc_pkg::*;
;
  // stimulus, driven at the rising edge
  logic        clk = 1'h0, rst_b = 1'h0, por_b = 1'h0, fc2 = 1'h0, fc0 = 1'h0, drv = 1'h0;
  logic        gsys = 1'h0, goff = 1'h1, gc1 = 1'h1, gc2 = 1'h1, trig = 1'h1, irq1 = 1'h1;
  logic        pin = 1'h1, vreq = 1'h0, va32 = 1'h0, slow = 1'h0, vwe = 1'h1;
  logic [7:0]  vadr = 8'h00;
  logic [31:0] ldat = 32'h0, vdat = 32'h0;
  vsc_wb_req_t wb = '0;
  // observed
  logic        ack, syscon, offrst, iso, retry, pout, oe, dir, l7, l1, lack, sel;
  logic [31:0] rdat, lrdat;
  vsc_lb_req_t lcyc, lreq;
  int          failures = 0, n_checks = 0;
  wire         pin_w = oe ? pout : pin;  // pulled high when nobody drives
  always #25 clk = ~clk;
  vsc_syscon dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_power_on_reset_in_b(por_b),
    .i_local_function_code_2(fc2), .i_local_function_code_0(fc0), .i_local_data(ldat),
    .i_syscon_detect_grant_in_b(gsys), .i_offcard_reset_grant_in_b(goff),
    .i_config_grant_in_first_b(gc1), .i_config_grant_in_second_b(gc2),
    .i_isolation_trigger_pin_b(trig), .i_irq1_b(irq1), .i_rmw_cycle_pin_in_b(pin_w),
    .i_rmw_drive_req(drv), .i_strobe_out_req(1'h0), .i_vme_slave_req(vreq),
    .i_vme_slave_a32(va32), .i_vme_slave_we(vwe), .i_vme_slave_adr(vadr),
    .i_vme_slave_dat(vdat), .i_device_chip_select(sel), .i_local_strobe(lreq.strobe),
    .i_local_we(lreq.we), .i_local_adr(lreq.adr), .i_local_wdat(lreq.dat), .i_wb(wb),
    .o_wb_ack(ack), .o_wb_dat(rdat), .o_syscon(syscon), .o_offcard_sys_reset(offrst),
    .o_bus_isolation_mode(iso), .o_retry_in(retry), .o_rmw_cycle_pin_out_b(pout),
    .o_rmw_cycle_pin_oe(oe), .o_strobe_buffer_direction(dir), .o_level7_irq(l7),
    .o_level1_irq(l1), .o_local_cycle(lcyc), .o_local_size_ack(lack), .o_local_rdat(lrdat));
  vsc_lb_decode u_dec (.i_ref_clk(clk), .i_rst_b(rst_b), .i_cycle(lcyc), .i_ack(lack),
    .i_slow(slow), .o_sel(sel), .o_req(lreq));
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic wb_io(logic we, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    wb <= '{1'h1, 1'h1, we, a, 4'hf, d};
    // no answer time assumed; only the watchdog ends a lost answer
    do begin
      @(posedge clk);
    end while (ack !== 1'h1);
    q = rdat;
    wb <= '0;
    @(posedge clk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d); logic [31:0] q; wb_io(1'h1, a, d, q); endtask
  task automatic rd(string nm, logic [7:0] a, logic [31:0] e, logic [31:0] m);
    logic [31:0] q;
    wb_io(1'h0, a, 32'h0, q);
    chk(nm, e, q & m);
  endtask
  task automatic do_reset(logic g);
    @(posedge clk);
    rst_b <= 1'h0;
    gsys  <= g;
    repeat (12) @(posedge clk);
    rst_b <= 1'h1;
    repeat (3) @(posedge clk);
  endtask
  task automatic strap(logic f0, logic [31:0] d);
    por_b <= 1'h0;
    fc2   <= 1'h1;
    fc0   <= f0;
    ldat  <= d;
    @(posedge clk);
    por_b <= 1'h1;
    repeat (3) @(posedge clk);
  endtask
  task automatic iso_off; wr(VSC_OFS_ISOCTL, 32'h6); chk("iso_off", 32'h0, iso); endtask
  task automatic t_syscon;
    do_reset(1'h1);
    chk("syscon_off", 32'h0, syscon);
    gsys <= 1'h0;
    repeat (2) @(posedge clk);
    chk("syscon_held", 32'h0, syscon);
    do_reset(1'h0);
    goff <= 1'h0;
    gc1  <= 1'h0;
    @(posedge clk);
    chk("syscon_on", 32'h1, syscon);
    chk("offrst_on", 32'h1, offrst);
    goff <= 1'h1;
    rd("cfg_a", VSC_OFS_STATUS, 32'h3, 32'h7);
    gc1 <= 1'h1;
    gc2 <= 1'h0;
    rd("cfg_b", VSC_OFS_STATUS, 32'h5, 32'h7);
  endtask
  task automatic t_dual;
    drv <= 1'h1;
    @(posedge clk);
    chk("rmw_oe", 32'h1, oe);
    chk("strobe_dir", 32'h1, dir);
    wr(VSC_OFS_MODE, 32'h1);
    pin <= 1'h0;
    @(posedge clk);
    chk("retry_oe", 32'h0, oe);
    chk("retry_in", 32'h1, retry);
    pin <= 1'h1;
    drv <= 1'h0;
  endtask
  task automatic t_iso;
    chk("iso_reset", 32'h1, iso);
    iso_off();
    trig <= 1'h0;
    @(posedge clk);
    chk("iso_pin", 32'h1, iso);
    trig <= 1'h1;
    iso_off();
    wr(VSC_OFS_ISOCTL, 32'h7);
    chk("iso_soft", 32'h1, iso);
    wr(VSC_OFS_L7IE, 32'h1);
    iso_off();
    irq1 <= 1'h0;
    @(posedge clk);
    chk("iso_irq1", 32'h1, iso);
    chk("lvl7", 32'h1, l7);
    irq1 <= 1'h1;
    wr(VSC_OFS_GENERAL_CONTROL_REG, 32'h0);
    wr(VSC_OFS_VIE, 32'h2);
    iso_off();
    irq1 <= 1'h0;
    @(posedge clk);
    chk("irq1_only", 32'h0, iso);
    chk("lvl1", 32'h1, l1);
    irq1 <= 1'h1;
  endtask
  // vme writes land as local cycles, second one stalled, third a local read
  task automatic t_fwd;
    int n;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      slow <= (i == 1);
      vreq <= 1'h1;
      va32 <= (i == 1);
      vwe  <= (i != 2);
      vadr <= VSC_OFS_VIE;
      vdat <= (i == 1) ? 32'h2 : 32'h0;
      n = 0;
      do begin
        @(posedge clk);
        n++;
        if (n == 4) slow <= 1'h0;
      end while (lack !== 1'h1 && n < 50);
      vreq <= 1'h0;
      chk("size_ack", 32'h1, lack);
      chk("fwd_adr", {24'h0, VSC_OFS_VIE}, {24'h0, lcyc.adr});
      chk("fwd_we", (i == 2) ? 32'h0 : 32'h1, {31'h0, lcyc.we});
      if (i == 2) chk("local_rdat", 32'h2, lrdat);
      repeat (3) @(posedge clk);
      rd("vme_wr", VSC_OFS_VIE, (i == 0) ? 32'h0 : 32'h2, 32'hffff_ffff);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    do_reset(1'h0);
    t_syscon();
    strap(1'h1, 32'h1111_0000);
    rd("no_strap", VSC_OFS_BASE, 32'h0, 32'hffff_ffff);
    strap(1'h0, 32'ha5c3_0000);
    fc2 <= 1'h0;
    rd("base", VSC_OFS_BASE, 32'ha5c3_0000, 32'hffff_ffff);
    rd("autobase", VSC_OFS_STATUS, 32'h10, 32'h10);
    rd("slave_en", VSC_OFS_ISOCTL, 32'h6, 32'h6);
    t_dual();
    t_iso();
    t_fwd();
    // a system reset with the strap pins set and power-on high must not load
    fc2 <= 1'h1;
    do_reset(1'h0);
    rd("no_false_strap", VSC_OFS_BASE, 32'h0, 32'hffff_ffff);
    wr(8'h1c, 32'hffff_ffff);
    rd("unmapped", 8'h1c, 32'h0, 32'hffff_ffff);
    end_of_test();
  end
  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (10000) @(posedge clk);
    failures++;
    end_of_test();
  end
endmodule
